// *** rtl/accel_irq_consts.svh ***
`ifndef ACCEL_IRQ_CONSTS_SVH
`define ACCEL_IRQ_CONSTS_SVH

// ==========================================================
// register byte offsets
`define IRQ_EN_OFS        8'h20
`define IRQ_ROUTE_OFS     8'h24
`define IRQ_CFG_OFS       8'h28
`define IRQ_STAT_OFS      8'h2C

// ==========================================================
// reset values of the enable register per strap level, and of the routing and config registers
`define IRQ_EN_RST_LOW    8'h00
`define IRQ_EN_RST_HIGH   8'h20
`define IRQ_ROUTE_RST     8'h00
`define IRQ_CFG_RST       2'h0

// ==========================================================
// field positions
`define EN_STARTUP_OFF_BIT 1
`define CFG_POL_BIT        0
`define CFG_GATE_BIT       1

// ==========================================================
// operating mode codes
`define MODE_WAKE         2'h1
`define MODE_SLEEP        2'h2

// ==========================================================
// bus responses
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

// ==========================================================
// timing
`define CLK_PERIOD_NS     10
`define MOT_PULSE_MS      5
`define BOOT2_PULSE_MS    1
`define BOOT1_PULSE_US    10

`endif

// *** rtl/accel_irq_pkg.sv ***
package accel_irq_pkg;

  // ========================================================
  // event inputs from detectors, timebase and data path
  typedef struct packed {
    logic sample_ready;  // new sample pulse
    logic data_read;     // data output register read pulse
    logic buf_flag;      // buffer source flag level
    logic outside_flag;  // change detector outside band
    logic inside_flag;   // change detector inside band
    logic tilt_flag;     // orientation flag level
    logic doze_flag;     // auto-sleep flag level
    logic boot_done;     // boot complete pulse
    logic odr_tick;      // output_sample_rate tick
    logic active_mode;   // device in active mode
    logic buf_empty;     // buffer emptied by host
    logic soft_reset;    // soft reset pulse
  } evt_in_t;

  // open-drain or push-pull pin
  typedef struct packed {
    logic out;
    logic oe;
  } pin_t;

  // enable register, bit 7 down to bit 0
  typedef struct packed {
    logic sample_ready_irq_on;
    logic buffer_irq_on;
    logic outside_band_irq_on;
    logic inside_band_irq_on;
    logic tilt_pose_irq_on;
    logic auto_doze_irq_on;
    logic startup_irq_off;
    logic wake_out_on;
  } irq_en_t;

  typedef enum logic [1:0] {
    ST_SYNC0,
    ST_SYNC1,
    ST_LATCH,
    ST_RUN
  } phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        strap_s1;
    logic        strap_s2;
    logic        strap;
    irq_en_t     enable;
    logic [7:0]  route;
    logic [1:0]  cfg;
    logic        sample_ready_flag;
    logic [19:0] mot_cnt;
    logic [19:0] boot_cnt;
    logic        gate_hold;
    logic [1:0]  prev_mode;
    logic        prev_active;
    pin_t        pin_a;
    pin_t        pin_b;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

endpackage

// *** rtl/accel_interrupt_enable_output.sv ***
`timescale 1ns/1ps
`include "accel_irq_consts.svh"
// Summary of operation
// - strap high: pin a pulses low, open-drain, for motion pulse time
// - strap high: pulse repeats each sample tick until source flag clears
// - strap high: pin b carries only boot-complete low pulse
// - buffer gating: after wake/sleep change stop accepting until emptied
// - enable register layout bits 7..0, all read/write
// - reset: enable all zero, strap high sets bit 5 only
// - enable bits 7..2 and 0: 0 keeps event off both pins, 1 passes it by routing; strap high passes only bits 7..2 routed to pin a
// - strap low: data read clears sample flag and its pin level
// - strap high: data read clears flag, pin pulse ends by itself
// - entering active mode cuts a running sample pulse short
// - strap low: startup off bit 0 emits boot pulse, 1 suppresses; strap high always pulses; kept on soft reset
// - strap low: wake output holds active level in wake, opposite otherwise
// - strap low: routing bit 0 selects pin a, 1 selects pin b
module accel_interrupt_enable_output #(
  parameter int MOT_PULSE_CYC   = `MOT_PULSE_MS * 1000000 / `CLK_PERIOD_NS,
  parameter int BOOT2_PULSE_CYC = `BOOT2_PULSE_MS * 1000000 / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rstn,
  // axi4-lite write
  input  wire logic                   i_awvalid,
  output logic                        o_awready,
  input  wire logic [7:0]             i_awaddr,
  input  wire logic                   i_wvalid,
  output logic                        o_wready,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  output logic                        o_bvalid,
  input  wire logic                   i_bready,
  output logic [1:0]                  o_bresp,
  // axi4-lite read
  input  wire logic                   i_arvalid,
  output logic                        o_arready,
  input  wire logic [7:0]             i_araddr,
  output logic                        o_rvalid,
  input  wire logic                   i_rready,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  // device events and mode
  input  wire accel_irq_pkg::evt_in_t i_evt,
  input  wire logic [1:0]             i_sys_mode,
  // strap pin
  input  wire logic                   i_boot_strap,
  // interrupt pins and buffer gate
  output accel_irq_pkg::pin_t         o_irq_pin_a,
  output accel_irq_pkg::pin_t         o_irq_pin_b,
  output logic                        o_buf_accept
);

  // ========================================================
  // constants
  localparam int BOOT1_CYC_I = `BOOT1_PULSE_US * 1000 / `CLK_PERIOD_NS;
  localparam logic [19:0] MOT_CYC   = 20'(MOT_PULSE_CYC);
  localparam logic [19:0] BOOT2_CYC = 20'(BOOT2_PULSE_CYC);
  localparam logic [19:0] BOOT1_CYC = 20'(BOOT1_CYC_I);

  accel_irq_pkg::state_t s_r;
  accel_irq_pkg::state_t s_nxt;

  logic       run;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic [5:0] src_act;
  logic [5:0] src_b;
  logic       wake_lvl;
  logic       trans;
  logic       lvl_a;
  logic       lvl_b;
  logic       act_a;
  logic       act_b;

  // ========================================================
  // bus handshakes, combinational from state
  assign run       = (s_r.phase == accel_irq_pkg::ST_RUN);
  assign o_awready = run && !s_r.aw_held && !s_r.bvalid;
  assign o_wready  = run && !s_r.w_held && !s_r.bvalid;
  assign o_arready = run && !s_r.rvalid;
  assign aw_hs     = i_awvalid && o_awready;
  assign w_hs      = i_wvalid && o_wready;
  assign ar_hs     = i_arvalid && o_arready;

  // registered outputs
  assign o_bvalid     = s_r.bvalid;
  assign o_bresp      = s_r.bresp;
  assign o_rvalid     = s_r.rvalid;
  assign o_rdata      = s_r.rdata;
  assign o_rresp      = s_r.rresp;
  assign o_irq_pin_a  = s_r.pin_a;
  assign o_irq_pin_b  = s_r.pin_b;
  assign o_buf_accept = run && !s_r.gate_hold;

  // ========================================================
  // source gating: enable bits 7..2 against flags
  assign src_act = {s_r.sample_ready_flag, i_evt.buf_flag,
                    i_evt.outside_flag, i_evt.inside_flag,
                    i_evt.tilt_flag, i_evt.doze_flag}
                   & s_r.enable[7:2];
  assign src_b   = s_r.route[7:2];
  assign wake_lvl = (i_sys_mode == `MODE_WAKE);
  assign trans = ((s_r.prev_mode == `MODE_WAKE) &&
                  (i_sys_mode == `MODE_SLEEP)) ||
                 ((s_r.prev_mode == `MODE_SLEEP) &&
                  (i_sys_mode == `MODE_WAKE));

  // strap low: level on each pin as OR of its routed sources
  assign lvl_a = (|(src_act & ~src_b)) ||
                 ((s_r.boot_cnt != 20'h00000) && !s_r.route[1]) ||
                 (s_r.enable.wake_out_on && !s_r.route[0] &&
                  wake_lvl);
  assign lvl_b = (|(src_act & src_b)) ||
                 ((s_r.boot_cnt != 20'h00000) && s_r.route[1]) ||
                 (s_r.enable.wake_out_on && s_r.route[0] &&
                  wake_lvl);

  // strap high: pin b sources are unrouted from both pins
  assign act_a = s_r.mot_cnt != 20'h00000;
  assign act_b = s_r.boot_cnt != 20'h00000;

  // ========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    // strap synchroniser, first stage feeds only the second
    s_nxt.strap_s1    = i_boot_strap;
    s_nxt.strap_s2    = s_r.strap_s1;
    s_nxt.prev_mode   = i_sys_mode;
    s_nxt.prev_active = i_evt.active_mode;

    // strap is caught once, after the synchroniser has filled
    case (s_r.phase)
      accel_irq_pkg::ST_SYNC0: begin
        s_nxt.phase = accel_irq_pkg::ST_SYNC1;
      end
      accel_irq_pkg::ST_SYNC1: begin
        s_nxt.phase = accel_irq_pkg::ST_LATCH;
      end
      accel_irq_pkg::ST_LATCH: begin
        s_nxt.phase  = accel_irq_pkg::ST_RUN;
        s_nxt.strap  = s_r.strap_s2;
        s_nxt.enable = s_r.strap_s2 ? `IRQ_EN_RST_HIGH
                                    : `IRQ_EN_RST_LOW;
      end
      accel_irq_pkg::ST_RUN: begin
      end
      default: begin
        s_nxt.phase = accel_irq_pkg::ST_SYNC0;
      end
    endcase

    // write channel capture, either order
    if (aw_hs) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = i_awaddr;
    end
    if (w_hs) begin
      s_nxt.w_held  = 1'b1;
      s_nxt.w_data  = i_wdata[7:0];
      s_nxt.w_lane0 = i_wstrb[0];
    end
    if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // commit once both halves are held
    if (s_r.aw_held && s_r.w_held) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `AXI_OKAY;
      case (s_r.aw_addr)
        `IRQ_EN_OFS: begin
          if (s_r.w_lane0) begin
            s_nxt.enable = s_r.w_data;
          end
        end
        `IRQ_ROUTE_OFS: begin
          if (s_r.w_lane0) begin
            s_nxt.route = s_r.w_data;
          end
        end
        `IRQ_CFG_OFS: begin
          if (s_r.w_lane0) begin
            s_nxt.cfg = s_r.w_data[1:0];
          end
        end
        `IRQ_STAT_OFS: begin
        end
        default: begin
          s_nxt.bresp = `AXI_SLVERR;
        end
      endcase
    end

    // soft reset keeps the startup suppression bit
    if (i_evt.soft_reset && run) begin
      s_nxt.enable = s_r.strap ? `IRQ_EN_RST_HIGH : `IRQ_EN_RST_LOW;
      s_nxt.enable.startup_irq_off = s_r.enable.startup_irq_off;
      s_nxt.route = `IRQ_ROUTE_RST;
      s_nxt.cfg   = `IRQ_CFG_RST;
    end

    // read channel
    if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `AXI_OKAY;
      case (i_araddr)
        `IRQ_EN_OFS:    s_nxt.rdata = {24'h000000, s_r.enable};
        `IRQ_ROUTE_OFS: s_nxt.rdata = {24'h000000, s_r.route};
        `IRQ_CFG_OFS:   s_nxt.rdata = {30'h00000000, s_r.cfg};
        `IRQ_STAT_OFS: begin
          s_nxt.rdata = {26'h0000000, s_r.strap, s_r.gate_hold,
                         s_r.sample_ready_flag, act_a, lvl_a, lvl_b};
        end
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = `AXI_SLVERR;
        end
      endcase
    end

    // sample flag: a new sample beats a read in the same cycle
    if (i_evt.data_read) begin
      s_nxt.sample_ready_flag = 1'b0;
    end
    if (i_evt.sample_ready && run) begin
      s_nxt.sample_ready_flag = 1'b1;
    end

    // buffer gating, a new transition beats an empty
    if (i_evt.buf_empty) begin
      s_nxt.gate_hold = 1'b0;
    end
    if (run && s_r.cfg[`CFG_GATE_BIT] && trans) begin
      s_nxt.gate_hold = 1'b1;
    end

    // motion pulse timer, strap high only; reads never stop it
    if (act_a) begin
      s_nxt.mot_cnt = s_r.mot_cnt - 20'h00001;
    end
    if (run && s_r.strap && i_evt.odr_tick && !act_a &&
        (|(src_act & ~src_b))) begin
      s_nxt.mot_cnt = MOT_CYC;
    end
    if (i_evt.active_mode && !s_r.prev_active) begin
      s_nxt.mot_cnt = 20'h00000;
    end

    // boot pulse timer, length per strap level
    if (act_b) begin
      s_nxt.boot_cnt = s_r.boot_cnt - 20'h00001;
    end
    if (run && i_evt.boot_done) begin
      if (s_r.strap) begin
        s_nxt.boot_cnt = BOOT2_CYC;
      end else if (!s_r.enable.startup_irq_off) begin
        s_nxt.boot_cnt = BOOT1_CYC;
      end
    end

    // pin drive: open-drain low pulses or push-pull with polarity
    if (!run) begin
      s_nxt.pin_a = '0;
      s_nxt.pin_b = '0;
    end else if (s_r.strap) begin
      s_nxt.pin_a.out = 1'b0;
      s_nxt.pin_a.oe  = act_a;
      s_nxt.pin_b.out = 1'b0;
      s_nxt.pin_b.oe  = act_b;
    end else begin
      s_nxt.pin_a.oe  = 1'b1;
      s_nxt.pin_a.out = s_r.cfg[`CFG_POL_BIT] ? lvl_a : !lvl_a;
      s_nxt.pin_b.oe  = 1'b1;
      s_nxt.pin_b.out = s_r.cfg[`CFG_POL_BIT] ? lvl_b : !lvl_b;
    end
  end

  // ========================================================
  // state register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================
  // checks
  en_reset_val_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && $past(s_r.phase) == accel_irq_pkg::ST_LATCH) |->
      s_r.enable == (s_r.strap ? 8'h20 : 8'h00))
    else $error("enable reset value wrong for strap");

  flag_clear_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && i_evt.data_read && !i_evt.sample_ready) |=>
      !s_r.sample_ready_flag)
    else $error("data read did not clear sample flag");

  flag_set_wins_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && i_evt.sample_ready) |=> s_r.sample_ready_flag)
    else $error("sample event lost");

  pulse_on_tick_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    $rose(s_r.mot_cnt != 20'h00000) |->
      $past(i_evt.odr_tick) && s_r.mot_cnt == MOT_CYC)
    else $error("motion pulse started off tick or wrong length");

  pin_a_drain_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && s_r.strap) |-> ##1 (!s_r.pin_a.out &&
      s_r.pin_a.oe == $past(act_a)))
    else $error("pin a not open-drain motion pulse");

  pin_b_boot_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && s_r.strap && $past(run) && s_r.pin_b.oe) |->
      $past(s_r.boot_cnt != 20'h00000) && !s_r.pin_b.out)
    else $error("pin b driven without boot pulse");

  cut_short_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (i_evt.active_mode && !s_r.prev_active) |=>
      s_r.mot_cnt == 20'h00000)
    else $error("pulse not cut on active entry");

  buf_gate_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && s_r.cfg[1] && trans) |=> !o_buf_accept)
    else $error("buffer still accepting after mode change");

  all_off_a: assert property (
    @(posedge i_sys_clk) disable iff (!i_rstn)
    (run && !s_r.strap && s_r.cfg[0] && s_r.enable == 8'h00 &&
     s_r.boot_cnt == 20'h00000) |=> !s_r.pin_a.out && !s_r.pin_b.out)
    else $error("disabled events reached a pin");

endmodule

// *** tb/irq_host_monitor.sv ***
`timescale 1ns/1ps
// ==========================================================
// host side: pulled-up irq lines and low pulse statistics
module irq_host_monitor (
  // clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_rstn,
  // pins from the device
  input  wire accel_irq_pkg::pin_t i_pin_a,
  input  wire accel_irq_pkg::pin_t i_pin_b,
  // resolved line levels and pulse stats
  output logic                     o_lvl_a,
  output logic                     o_lvl_b,
  output logic [7:0]               o_cnt_a,
  output logic [7:0]               o_cnt_b,
  output logic [15:0]              o_len_a,
  output logic [15:0]              o_len_b
);
  logic [15:0] run_a_r;
  logic [15:0] run_b_r;

  // a released line is pulled up, never left at its last value
  assign o_lvl_a = i_pin_a.oe ? i_pin_a.out : 1'b1;
  assign o_lvl_b = i_pin_b.oe ? i_pin_b.out : 1'b1;

  // a pulse is counted when it ends, so its length is final
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_a_r <= 16'h0000;
      run_b_r <= 16'h0000;
      o_cnt_a <= 8'h00;
      o_cnt_b <= 8'h00;
      o_len_a <= 16'h0000;
      o_len_b <= 16'h0000;
    end else begin
      if (!o_lvl_a) begin
        run_a_r <= run_a_r + 16'h0001;
      end else if (run_a_r != 16'h0000) begin
        o_len_a <= run_a_r;
        o_cnt_a <= o_cnt_a + 8'h01;
        run_a_r <= 16'h0000;
      end
      if (!o_lvl_b) begin
        run_b_r <= run_b_r + 16'h0001;
      end else if (run_b_r != 16'h0000) begin
        o_len_b <= run_b_r;
        o_cnt_b <= o_cnt_b + 8'h01;
        run_b_r <= 16'h0000;
      end
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "accel_irq_consts.svh"
module tb;
  // ========================================================
  // signals
  localparam logic [11:0] EV_SAMPLE = 12'h800;
  localparam logic [11:0] EV_READ   = 12'h400;
  localparam logic [11:0] EV_BOOT   = 12'h010;
  localparam logic [11:0] EV_TICK   = 12'h008;
  localparam logic [11:0] EV_EMPTY  = 12'h002;
  localparam logic [11:0] EV_SOFT   = 12'h001;
  logic        sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, strap, accept;
  logic        lvl_a, lvl_b;
  logic [7:0]  awaddr, araddr, cnt_a, cnt_b, base, base_b;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, mode, resp;
  logic [15:0] len_a, len_b;
  accel_irq_pkg::evt_in_t evt;
  accel_irq_pkg::pin_t    pin_a, pin_b;
  int          err_total, total_checks, cyc;

  // short pulse counts keep the run brief
  accel_interrupt_enable_output #(
    .MOT_PULSE_CYC   (20),
    .BOOT2_PULSE_CYC (10)
  ) dut_u (
    .i_sys_clk(sys_clk), .i_rstn(rstn),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_evt(evt), .i_sys_mode(mode),
    .i_boot_strap(strap), .o_irq_pin_a(pin_a), .o_irq_pin_b(pin_b),
    .o_buf_accept(accept)
  );

  irq_host_monitor host_u (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_pin_a(pin_a),
    .i_pin_b(pin_b), .o_lvl_a(lvl_a), .o_lvl_b(lvl_b),
    .o_cnt_a(cnt_a), .o_cnt_b(cnt_b), .o_len_a(len_a), .o_len_b(len_b)
  );

  // ========================================================
  // clock and hang guard
  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ========================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // bit by bit, so that level fields set in the same step survive
  task automatic pulse(input logic [11:0] m);
    for (int i = 0; i < 12; i++) begin
      if (m[i]) begin
        evt[i] <= 1'b1;
      end
    end
    @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      if (m[i]) begin
        evt[i] <= 1'b0;
      end
    end
  endtask

  // one sample tick, then the rest of a 40 cycle period
  task automatic ticks(input int n);
    repeat (n) begin
      pulse(EV_TICK);
      repeat (39) @(posedge sys_clk);
    end
  endtask

  // strap is caught only after a reset, so each mode needs one
  task automatic rst(input logic s);
    rstn <= 1'b0;
    strap <= s;
    evt <= '0;
    mode <= 2'h0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask

  // ========================================================
  // main sequence
  initial begin
    sys_clk = 1'b0; rstn = 1'b0; strap = 1'b0; evt = '0; mode = 2'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h0; err_total = 0; total_checks = 0; cyc = 0;
    // strap low: register, routing, wake and gate
    rst(1'b0);
    rd(`IRQ_EN_OFS); chk("en_rst", 32'h0, rd_v);
    wr(`IRQ_EN_OFS, 32'hFF);
    chk("wr_resp", `AXI_OKAY, resp);
    rd(`IRQ_EN_OFS); chk("en_rw", 32'hFF, rd_v);
    chk("rd_resp", `AXI_OKAY, resp);
    rd(8'h40); chk("unmap", `AXI_SLVERR, resp);
    wr(`IRQ_EN_OFS, 32'h02);
    pulse(EV_SOFT);
    rd(`IRQ_EN_OFS); chk("soft", 32'h02, rd_v);
    base = cnt_a;
    pulse(EV_BOOT);
    repeat (1100) @(posedge sys_clk);
    chk("boot_off", base, cnt_a);
    wr(`IRQ_EN_OFS, 32'h00);
    pulse(EV_BOOT);
    repeat (1100) @(posedge sys_clk);
    chk("boot_cnt", base + 8'h01, cnt_a);
    chk("boot_len", 32'd1000, len_a);
    wr(`IRQ_EN_OFS, 32'h88);
    pulse(EV_SAMPLE);
    repeat (4) @(posedge sys_clk);
    chk("drdy_a", 32'h0, lvl_a);
    wr(`IRQ_ROUTE_OFS, 32'h80);
    repeat (4) @(posedge sys_clk);
    chk("route_a", 32'h1, lvl_a);
    chk("route_b", 32'h0, lvl_b);
    wr(`IRQ_ROUTE_OFS, 32'h00);
    evt.tilt_flag <= 1'b1;
    pulse(EV_READ);
    repeat (4) @(posedge sys_clk);
    chk("or_tilt", 32'h0, lvl_a);
    evt.tilt_flag <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("read_clr", 32'h1, lvl_a);
    wr(`IRQ_EN_OFS, 32'h00);
    evt.tilt_flag <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("en_off", 32'h1, lvl_a);
    evt.tilt_flag <= 1'b0;
    wr(`IRQ_EN_OFS, 32'h01);
    mode <= `MODE_WAKE;
    repeat (4) @(posedge sys_clk);
    chk("wake", 32'h0, lvl_a);
    mode <= `MODE_SLEEP;
    repeat (4) @(posedge sys_clk);
    chk("sleep", 32'h1, lvl_a);
    wr(`IRQ_CFG_OFS, 32'h02);
    pulse(EV_EMPTY);
    repeat (4) @(posedge sys_clk);
    chk("acc_on", 32'h1, accept);
    mode <= `MODE_WAKE;
    repeat (4) @(posedge sys_clk);
    chk("gated", 32'h0, accept);
    pulse(EV_EMPTY);
    repeat (4) @(posedge sys_clk);
    chk("ungated", 32'h1, accept);
    // active-high polarity: wake level drives pin a high
    wr(`IRQ_CFG_OFS, 32'h01);
    repeat (4) @(posedge sys_clk);
    chk("pol_hi", 32'h1, lvl_a);
    wr(`IRQ_EN_OFS, 32'h00);
    repeat (4) @(posedge sys_clk);
    chk("pol_off_a", 32'h0, lvl_a);
    chk("pol_off_b", 32'h0, lvl_b);
    // strap high: repeated pulses, boot pin, cut pulse
    rst(1'b1);
    rd(`IRQ_EN_OFS); chk("en_rst_h", 32'h20, rd_v);
    base = cnt_a;
    evt.outside_flag <= 1'b1;
    ticks(3);
    chk("rep_cnt", base + 8'h03, cnt_a);
    chk("mot_len", 32'd20, len_a);
    evt.outside_flag <= 1'b0;
    base = cnt_a;
    ticks(2);
    chk("rep_stop", base, cnt_a);
    base_b = cnt_b;
    pulse(EV_BOOT);
    repeat (20) @(posedge sys_clk);
    chk("boot_b", base_b + 8'h01, cnt_b);
    chk("boot_b_len", 32'd10, len_b);
    wr(`IRQ_ROUTE_OFS, 32'h20);
    evt.outside_flag <= 1'b1;
    base = cnt_a;
    base_b = cnt_b;
    ticks(2);
    chk("unr_a", base, cnt_a);
    chk("unr_b", base_b, cnt_b);
    evt.outside_flag <= 1'b0;
    wr(`IRQ_EN_OFS, 32'h80);
    pulse(EV_SAMPLE);
    pulse(EV_TICK);
    repeat (5) @(posedge sys_clk);
    pulse(EV_READ);
    repeat (30) @(posedge sys_clk);
    chk("drdy_len", 32'd20, len_a);
    base = cnt_a;
    ticks(1);
    chk("drdy_clr", base, cnt_a);
    pulse(EV_SAMPLE);
    pulse(EV_TICK);
    repeat (6) @(posedge sys_clk);
    evt.active_mode <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk("cut", 32'h1, len_a < 16'd20);
    tally_and_finish();
  end
endmodule
